//--- verilog/self_program_section_control_defines.vh
// constants for the self-programming section control block
`ifndef SELF_PROGRAM_SECTION_CONTROL_DEFINES_VH
`define SELF_PROGRAM_SECTION_CONTROL_DEFINES_VH

// flash word address width (16k words)
`define ADDR_W             14
// fixed first word of the no-concurrent-read region
`define NCR_START          14'h3800
// boot region start per boot size fuse code 3..0
`define BOOT_START_SZ3     14'h3f00
`define BOOT_START_SZ2     14'h3e00
`define BOOT_START_SZ1     14'h3c00
`define BOOT_START_SZ0     14'h3800
// lock pair encodings (1 = unprogrammed)
`define LOCK_NONE          2'h3
`define LOCK_NO_WRITE      2'h2
`define LOCK_NO_WR_RD      2'h0
`define LOCK_NO_READ       2'h1
// operation codes
`define OP_ERASE           2'h1
`define OP_WRITE           2'h2
`define OP_LOCK            2'h3

`endif

//--- verilog/self_program_section_control.v
// self-programming section access and protection control
`timescale 1ns/1ps
`include "self_program_section_control_defines.vh"

// Behaviour
// R1 - flash split into application and boot regions
// R2 - boot size fuses set region sizes
// R3 - store-program only starts from boot region
// R4 - boot code may target any address
// R5 - fixed concurrent and no-concurrent regions exist
// R6 - concurrent-region update keeps core running
// R7 - no-concurrent-region update halts core
// R8 - concurrent region unreadable while programming
// R9 - core avoids concurrent region while busy
// R10 - boot region always inside no-concurrent region
// R11 - busy flag reads one while blocked
// R12 - software clears busy flag after completion
// R13 - disable or move interrupts during update
// R14 - application protection from lock set 0
// R15 - boot protection from lock set 1
// R16 - lock pairs programmed independently
// R17 - boot code may rewrite boot pages
// R18 - four lock modes per pair encoding
// R19 - boot pair load blocking applies to application
// R20 - locks only set; cleared by chip erase
// R21 - target address captured at start
// R22 - halt released cycle after completion
module self_program_section_control (
    input  wire                 clk_i,
    input  wire                 rstn_i,
    input  wire                 ce_i,
    input  wire [1:0]           boot_size_fuses_i,
    input  wire [1:0]           lock_init_app_i,
    input  wire [1:0]           lock_init_boot_i,
    input  wire                 chip_erase_i,
    input  wire [`ADDR_W-1:0]   exec_addr_i,
    input  wire                 store_program_instr_i,
    input  wire [1:0]           store_op_i,
    input  wire [`ADDR_W-1:0]   store_addr_i,
    input  wire [3:0]           lock_wdata_i,
    input  wire                 load_req_i,
    input  wire [`ADDR_W-1:0]   load_addr_i,
    input  wire                 fetch_req_i,
    input  wire [`ADDR_W-1:0]   fetch_addr_i,
    input  wire                 busy_flag_clear_i,
    input  wire                 flash_done_i,
    output reg                  flash_start_o,
    output reg  [1:0]           flash_op_o,
    output reg  [`ADDR_W-1:0]   flash_addr_o,
    output reg                  core_halt_o,
    output reg                  store_rejected_o,
    output reg                  load_allowed_o,
    output reg                  fetch_valid_o,
    output reg                  concurrent_section_busy_flag_o,
    output reg  [1:0]           app_lock_o,
    output reg  [1:0]           boot_lock_o
);

    // idle takes stores; prog waits for the engine's done
    // pulse and drops any further store silently
    // (the core is either halted or running far code then)
    localparam ST_IDLE = 2'h0;
    localparam ST_PROG = 2'h1;

    // registered state, plus the combinational boot start decode
    reg  [1:0]          state;
    reg                 prog_in_ncr;
    reg                 locks_loaded;
    reg  [`ADDR_W-1:0]  boot_start;
    // address and lock decode
    wire                exec_in_boot;
    wire                tgt_in_boot;
    wire                tgt_in_ncr;
    wire                load_in_boot;
    wire                load_in_ncr;
    wire                fetch_in_ncr;
    wire [1:0]          tgt_lock;
    wire                write_ok;
    wire [1:0]          load_lock;
    wire                load_cross;
    wire                load_lock_ok;
    // store decode strobes
    wire [3*`ADDR_W-1:0] chan_addr;
    wire [2:0]          chan_in_ncr;
    wire                store_seen;
    wire                op_lock;
    wire                op_prog;
    wire                op_reject;
    wire                prog_done;
    wire                ncr_blocked;
    wire                clear_ok;
    genvar              ch;

    // R1 R2 boundary from boot size fuses
    always @* begin
        case (boot_size_fuses_i)
            2'h3:    boot_start = `BOOT_START_SZ3;
            2'h2:    boot_start = `BOOT_START_SZ2;
            2'h1:    boot_start = `BOOT_START_SZ1;
            default: boot_start = `BOOT_START_SZ0;
        endcase
    end

    // R5 R10 fixed split compare per address channel
    // every boot start sits at or above the split
    assign chan_addr = {fetch_addr_i, load_addr_i, store_addr_i};
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
            assign chan_in_ncr[ch] = (chan_addr[ch*`ADDR_W +: `ADDR_W] >= `NCR_START);
        end
    endgenerate

    // channel 0 store, 1 load, 2 fetch
    assign tgt_in_ncr   = chan_in_ncr[0];
    assign load_in_ncr  = chan_in_ncr[1];
    assign fetch_in_ncr = chan_in_ncr[2];

    // R1 boot region compares against the fuse boundary
    assign exec_in_boot = (exec_addr_i >= boot_start);
    assign tgt_in_boot  = (store_addr_i >= boot_start);
    assign load_in_boot = (load_addr_i >= boot_start);

    // R14 R15 R18 write blocked when the low lock bit is programmed
    // modes 11 and 01 leave writes open
    assign tgt_lock = tgt_in_boot ? boot_lock_o : app_lock_o;
    assign write_ok = (tgt_lock == `LOCK_NONE) || (tgt_lock == `LOCK_NO_READ);

    // R18 R19 load blocked only when crossing into the other region
    // modes 11 and 10 leave loads open
    assign load_lock    = load_in_boot ? boot_lock_o : app_lock_o;
    assign load_cross   = (load_in_boot != exec_in_boot);
    assign load_lock_ok = !load_cross || (load_lock == `LOCK_NONE)
                          || (load_lock == `LOCK_NO_WRITE);

    // store decode, only while idle with locks valid;
    // a store in any other cycle is dropped silently
    // and chip erase takes the cycle over a store
    assign store_seen  = (state == ST_IDLE) && store_program_instr_i
                         && !chip_erase_i && locks_loaded;
    // R3 lock-set and page operations need boot region code
    assign op_lock     = store_seen && exec_in_boot && (store_op_i == `OP_LOCK);
    assign op_prog     = store_seen && exec_in_boot && write_ok
                         && (store_op_i == `OP_ERASE || store_op_i == `OP_WRITE);
    assign op_reject   = store_seen && !op_lock && !op_prog;
    assign prog_done   = (state == ST_PROG) && flash_done_i;
    assign ncr_blocked = (state == ST_PROG) && prog_in_ncr;
    // set beats clear: a clear is dropped in a store cycle
    assign clear_ok    = (state == ST_IDLE) && busy_flag_clear_i && !store_seen;

    // sequencer: idle until a page operation, then wait for done
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (op_prog) begin
                        state <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    if (flash_done_i) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // start pulse for the engine, one cycle per accepted page operation
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            flash_start_o <= 1'b0;
        end else if (ce_i) begin
            flash_start_o <= op_prog;
        end
    end

    // R4 R17 any target whose lock pair allows writes is accepted, boot pages included
    // R21 operation and address latched at start, so the
    // core may reuse its pointer while the page is busy
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            flash_op_o   <= 2'h0;
            flash_addr_o <= {`ADDR_W{1'b0}};
            prog_in_ncr  <= 1'b0;
        end else if (ce_i) begin
            if (op_prog) begin
                flash_op_o   <= store_op_i;
                flash_addr_o <= store_addr_i;
                prog_in_ncr  <= tgt_in_ncr;
            end
        end
    end

    // R7 halt the core for a no-concurrent target
    // R6 a concurrent target leaves the core running
    // R22 halt dropped the cycle after done
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            core_halt_o <= 1'b0;
        end else if (ce_i) begin
            if (op_prog) begin
                core_halt_o <= tgt_in_ncr;
            end else if (prog_done) begin
                core_halt_o <= 1'b0;
            end
        end
    end

    // R3 R18 one-cycle reject pulse for refused stores
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            store_rejected_o <= 1'b0;
        end else if (ce_i) begin
            store_rejected_o <= op_reject;
        end
    end

    // R11 busy flag set at every start
    // R12 held until software clears it back in idle
    // a clear in the start cycle is lost on purpose
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            concurrent_section_busy_flag_o <= 1'b0;
        end else if (ce_i) begin
            if (op_prog) begin
                concurrent_section_busy_flag_o <= 1'b1;
            end else if (clear_ok) begin
                concurrent_section_busy_flag_o <= 1'b0;
            end
        end
    end

    // locks valid from the first enabled edge after reset;
    // stores wait for this so no check uses the reset value
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            locks_loaded <= 1'b0;
        end else if (ce_i) begin
            locks_loaded <= 1'b1;
        end
    end

    // R14 R20 application pair: load once, erase to ones
    // R16 a lock-set only clears bits of this pair
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            app_lock_o <= `LOCK_NONE;
        end else if (ce_i) begin
            if (chip_erase_i && state == ST_IDLE) begin
                app_lock_o <= `LOCK_NONE;
            end else if (!locks_loaded) begin
                app_lock_o <= lock_init_app_i;
            end else if (op_lock) begin
                app_lock_o <= app_lock_o & lock_wdata_i[1:0];
            end
        end
    end

    // R15 R20 boot pair: load once, erase to ones
    // R16 a lock-set only clears bits of this pair
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            boot_lock_o <= `LOCK_NONE;
        end else if (ce_i) begin
            if (chip_erase_i && state == ST_IDLE) begin
                boot_lock_o <= `LOCK_NONE;
            end else if (!locks_loaded) begin
                boot_lock_o <= lock_init_boot_i;
            end else if (op_lock) begin
                boot_lock_o <= boot_lock_o & lock_wdata_i[3:2];
            end
        end
    end

    // R6 R8 fetch answer: nothing while the core is halted,
    // and nothing from the concurrent region while busy
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            fetch_valid_o <= 1'b0;
        end else if (ce_i) begin
            fetch_valid_o <= fetch_req_i && !ncr_blocked
                             && !(concurrent_section_busy_flag_o && !fetch_in_ncr);
        end
    end

    // R8 R19 load answer: lock pair of the read region
    // applies only when the load crosses regions
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            load_allowed_o <= 1'b0;
        end else if (ce_i) begin
            load_allowed_o <= load_req_i && load_lock_ok
                              && !ncr_blocked
                              && !(concurrent_section_busy_flag_o && !load_in_ncr);
        end
    end

endmodule // self_program_section_control

//--- tb/self_program_section_control_asserts.sv
// assertions on the self-programming section control ports
`timescale 1ns/1ps
`include "self_program_section_control_defines.vh"
module self_program_section_control_asserts (
    input wire logic                clk_i, rstn_i, ce_i, store_program_instr_i, flash_done_i,
    input wire logic                flash_start_o, core_halt_o, fetch_valid_o,
    input wire logic                concurrent_section_busy_flag_o,
    input wire logic [1:0]          boot_size_fuses_i,
    input wire logic [`ADDR_W-1:0]  exec_addr_i, store_addr_i, fetch_addr_i, flash_addr_o
);
    // first boot word for the present fuse code
    wire [`ADDR_W-1:0] boot_start = boot_size_fuses_i[1]
        ? (boot_size_fuses_i[0] ? `BOOT_START_SZ3 : `BOOT_START_SZ2)
        : (boot_size_fuses_i[0] ? `BOOT_START_SZ1 : `BOOT_START_SZ0);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence ncr_start; flash_start_o && flash_addr_o >= `NCR_START; endsequence
    sequence done_in_halt; core_halt_o && flash_done_i && ce_i; endsequence
    start_boot_a: assert property (flash_start_o && $past(ce_i) |->
        $past(store_program_instr_i) && $past(exec_addr_i) >= $past(boot_start))
        else $error("start from app code");
    addr_capture_a: assert property (flash_start_o && $past(ce_i) |->
        flash_addr_o == $past(store_addr_i))
        else $error("target not captured");
    halt_ncr_a: assert property (ncr_start |-> core_halt_o) else $error("core not halted");
    run_cr_a: assert property (flash_start_o && flash_addr_o < `NCR_START |-> !core_halt_o)
        else $error("core halted");
    busy_set_a: assert property (flash_start_o |-> concurrent_section_busy_flag_o)
        else $error("busy flag low");
    halt_hold_a: assert property (core_halt_o && !flash_done_i && ce_i |=> core_halt_o)
        else $error("halt dropped early");
    halt_release_a: assert property (done_in_halt |=> !core_halt_o) else $error("halt held");
    fetch_block_a: assert property (fetch_valid_o && $past(ce_i) |->
        !($past(concurrent_section_busy_flag_o) && $past(fetch_addr_i) < `NCR_START))
        else $error("blocked fetch served");
endmodule // self_program_section_control_asserts
bind self_program_section_control self_program_section_control_asserts u_chk (.*);

//--- tb/flash_engine_model.sv
// flash engine model answering each start with a late done pulse
`timescale 1ns/1ps
module flash_engine_model #(parameter integer DLY = 4) (
    input  wire clk_i,
    input  wire start_i,
    output reg  done_o = 1'b0,
    output reg  busy_o = 1'b0
);
    reg [7:0] cnt = 8'h00;
    // count down the page operation, then pulse done
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (start_i) begin
            busy_o <= 1'b1;
            cnt <= DLY;
        end else if (busy_o && cnt == 8'h01) begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
        end else if (busy_o) cnt <= cnt - 8'h01;
    end
endmodule // flash_engine_model

//--- tb/self_program_section_control_test.sv
// self-checking bench for the self-programming section control block
`timescale 1ns/1ps
`include "self_program_section_control_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module self_program_section_control_test;
    reg clk_i = 0, rstn_i = 0, spi = 0, erase = 0, ld = 0, fe = 0, clr = 0;
    reg [1:0] fuses = 2'h3, op = 2'h0;
    reg [13:0] ex = 0, sa = 0, ra = 0;
    reg [3:0] lw = 4'hf;
    reg [1:0] linit = 2'h3;
    reg ce = 1;
    wire start, halt, rej, lok, fok, busy, done, fbusy;
    wire [1:0] fop, al, bl;
    wire [13:0] faddr;
    integer n_mismatch = 0, check_count = 0, i;
    always #12.5 clk_i = ~clk_i;
    self_program_section_control dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .boot_size_fuses_i(fuses), .lock_init_app_i(linit), .lock_init_boot_i(2'h3),
        .chip_erase_i(erase), .exec_addr_i(ex), .store_program_instr_i(spi), .store_op_i(op),
        .store_addr_i(sa), .lock_wdata_i(lw), .load_req_i(ld), .load_addr_i(ra), .fetch_req_i(fe),
        .fetch_addr_i(ra), .busy_flag_clear_i(clr), .flash_done_i(done), .flash_start_o(start),
        .flash_op_o(fop), .flash_addr_o(faddr), .core_halt_o(halt), .store_rejected_o(rej),
        .load_allowed_o(lok), .fetch_valid_o(fok), .concurrent_section_busy_flag_o(busy),
        .app_lock_o(al), .boot_lock_o(bl));
    flash_engine_model #(.DLY(4)) fm (.clk_i(clk_i), .start_i(start), .done_o(done), .busy_o(fbusy));
    task step; begin @(posedge clk_i); #2; end endtask
    task complete_run; begin
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    end endtask
    // one store request, pointer moved away once taken
    task store(input [1:0] o, input [13:0] a, input [13:0] e, input ok); begin
        op = o; sa = a; ex = e; spi = 1; step; spi = 0; sa = ~a;
        `CHK("flash_start_o", ok, start)
        `CHK("store_rejected_o", !ok, rej)
        if (ok) `CHK("flash_addr_o", a, faddr)
        if (ok) `CHK("flash_op_o", o, fop)
        step;
    end endtask
    // one load or fetch request, answered next cycle
    task access(input l, input [13:0] a, input exp); begin
        ld = l; fe = !l; ra = a; step;
        `CHK(l ? "load_allowed_o" : "fetch_valid_o", exp, l ? lok : fok)
        ld = 0; fe = 0; step;
    end endtask
    task wait_done; begin
        for (i = 0; i < 50 && fbusy; i = i + 1) step;
        if (fbusy) begin n_mismatch++; complete_run; end
        step;
        `CHK("core_halt_o", 1'b0, halt)
    end endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #2 rstn_i = 1; step; step;
        `CHK("app_lock_o", `LOCK_NONE, al)
        `CHK("boot_lock_o", `LOCK_NONE, bl)
        store(`OP_ERASE, 14'h0100, 14'h0200, 0);
        // larger boot region code lets 0x3e10 start a store
        fuses = 2'h2;
        store(`OP_ERASE, 14'h3900, 14'h3e10, 1);
        `CHK("core_halt_o", 1'b1, halt)
        `CHK("busy", 1'b1, busy)
        wait_done;
        fuses = 2'h3;
        store(`OP_WRITE, 14'h0200, 14'h3f10, 1);
        `CHK("core_halt_o", 1'b0, halt)
        // core keeps off the concurrent region while it is programmed
        access(0, 14'h0100, 0);
        access(0, 14'h3900, 1);
        wait_done;
        `CHK("busy", 1'b1, busy)
        clr = 1; step; clr = 0;
        `CHK("busy", 1'b0, busy)
        access(0, 14'h0100, 1);
        access(1, 14'h0100, 1);
        store(`OP_WRITE, 14'h3f40, 14'h3f10, 1);
        wait_done;
        // lock-set clears only the application low bit
        op = `OP_LOCK; lw = 4'he; spi = 1; step; spi = 0; step; step;
        wait_done;
        `CHK("app_lock_o", `LOCK_NO_WRITE, al)
        `CHK("boot_lock_o", `LOCK_NONE, bl)
        store(`OP_WRITE, 14'h0200, 14'h3f10, 0);
        store(`OP_WRITE, 14'h3f40, 14'h3f10, 1);
        wait_done;
        // boot pair to load-blocked mode, application pair untouched
        op = `OP_LOCK; lw = 4'h7; spi = 1; step; spi = 0; step;
        `CHK("boot_lock_o", `LOCK_NO_READ, bl)
        `CHK("app_lock_o", `LOCK_NO_WRITE, al)
        ex = 14'h0200;
        access(1, 14'h3f40, 0);
        ex = 14'h3f10;
        access(1, 14'h3f40, 1);
        erase = 1; step; erase = 0; step;
        `CHK("app_lock_o", `LOCK_NONE, al)
        `CHK("boot_lock_o", `LOCK_NONE, bl)
        // clock enable low: a valid store must not start
        ce = 0; op = `OP_WRITE; sa = 14'h3f40; spi = 1; step; spi = 0; step;
        `CHK("flash_start_o", 1'b0, start)
        `CHK("store_rejected_o", 1'b0, rej)
        ce = 1; step;
        // second reset, application pair loaded as fully locked
        rstn_i = 0; linit = 2'h0; step; step;
        `CHK("app_lock_o", `LOCK_NONE, al)
        rstn_i = 1; step;
        `CHK("app_lock_o", `LOCK_NO_WR_RD, al)
        complete_run;
    end
endmodule // self_program_section_control_test
